// file: src/gp56_pkg.sv
// Purpose: constants shared by the two-port general purpose i/o block
// Assumes: 16-bit register address, 8-bit register data
// Notes: port five registers sit one offset below the port six ones
package gp56_pkg;
  localparam int unsigned GP56_WIDTH = 8;
  localparam logic [15:0] GP56_ADDR_P5_DATA = 16'hffd8;
  localparam logic [15:0] GP56_ADDR_P5_DIR = 16'hffe8;
  localparam logic [15:0] GP56_ADDR_P5_PULLUP = 16'hffef;
  localparam logic [15:0] GP56_ADDR_P6_DATA = 16'hffd9;
  localparam logic [15:0] GP56_ADDR_P6_DIR = 16'hffe9;
  localparam logic [7:0] GP56_RST_VAL = 8'h00;
  localparam logic [7:0] GP56_WO_READ = 8'hff;
  localparam logic [7:0] GP56_UNMAPPED_READ = 8'h00;
  localparam int unsigned GP56_TIMER_PIN = 6;
  localparam int unsigned GP56_TRIG_PIN = 5;
  // power modes, one-hot
  typedef enum logic [5:0] {
    GP56_MODE_ACTIVE = 6'h01,
    GP56_MODE_SUBACTIVE = 6'h02,
    GP56_MODE_SLEEP = 6'h04,
    GP56_MODE_SUBSLEEP = 6'h08,
    GP56_MODE_STANDBY = 6'h10,
    GP56_MODE_WATCH = 6'h20
  } gp56_mode_t;
endpackage : gp56_pkg

// file: src/gp56_pin_ctl.sv
// Purpose: pin driver control for one 8-bit port
// Assumes: drive values are registered by the caller
// Notes: holds the last drive in retaining modes
`timescale 1ns/100ps
`default_nettype none
module gp56_pin_ctl #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] power_mode,
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] data,
  input wire logic [WIDTH-1:0] pullup_req,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pullup_on
);
  logic [WIDTH-1:0] out_q, out_d, oe_q, oe_d, pu_q, pu_d;
  wire logic retain = (power_mode == gp56_pkg::GP56_MODE_SLEEP) ||
                      (power_mode == gp56_pkg::GP56_MODE_SUBSLEEP);
  wire logic floating = (power_mode == gp56_pkg::GP56_MODE_STANDBY) ||
                        (power_mode == gp56_pkg::GP56_MODE_WATCH);
  wire logic [WIDTH-1:0] pu_eff = pullup_req & ~dir; // [R5]

  if (WIDTH < 1) begin : g_width_check
    $error("gp56_pin_ctl: port needs at least one pin");
  end

  // next drive per mode; unknown mode codes behave as active
  always_comb begin
    out_d = data;
    oe_d = dir; // [R1] [R11]
    pu_d = pu_eff;
    if (retain) begin
      out_d = out_q; // [R3]
      oe_d = oe_q;
      pu_d = pu_q;
    end else if (floating) begin
      out_d = pu_eff; // [R4]
      oe_d = pu_eff; // [R3] [R4]
    end
  end

  // reset leaves every pin released and pull-ups off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
      oe_q <= '0; // [R3]
      pu_q <= '0; // [R6]
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      pu_q <= pu_d;
    end
  end

  assign pin_o = out_q;
  assign pin_oe = oe_q;
  assign pullup_on = pu_q;
endmodule : gp56_pin_ctl
`default_nettype wire

// file: src/gp56_top.sv
// Purpose: general purpose i/o ports five and six with register access
// Assumes: pins synchronous to clk; power mode given by system control
// Notes: pin drive registered, one cycle after the register write
// Functional notes
// [R1] port five direction bit selects input/output
// [R2] port five pins feed interrupts, timer, trigger
// [R3] pins released in reset, held/floating per mode
// [R4] enabled pull-up drives high in standby/watch
// [R5] pull-up on only for input with control
// [R6] all pull-ups off after reset
// [R7] port six data/direction registers, reset zero
// [R8] port five read: data if output, pin if input
// [R9] port five direction reads all ones
// [R10] port six read: data if output, pin if input
// [R11] port six direction bit set means output
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module gp56_top #(
  parameter int unsigned WIDTH = gp56_pkg::GP56_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  // register bus, read data one cycle after the strobe
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // power state from system control, one-hot
  input wire logic [5:0] power_mode,
  // port five pins, with pull-up control
  input wire logic [WIDTH-1:0] p5_pin_i,
  output logic [WIDTH-1:0] p5_pin_o,
  output logic [WIDTH-1:0] p5_pin_oe,
  output logic [WIDTH-1:0] p5_pullup_on,
  // port six pins, no pull-ups
  input wire logic [WIDTH-1:0] p6_pin_i,
  output logic [WIDTH-1:0] p6_pin_o,
  output logic [WIDTH-1:0] p6_pin_oe,
  // taps toward interrupt, timer and converter logic
  output logic [WIDTH-1:0] ext_irq_in,
  output logic timer_event_in,
  output logic converter_trigger_in
);
  // the register map is byte wide, so the port must be too
  if (WIDTH != 8) begin : g_width_check
    $error("gp56_top: register map serves exactly 8 bits");
  end

  // the shared taps must land on real pins of the port
  if (gp56_pkg::GP56_TIMER_PIN >= WIDTH ||
      gp56_pkg::GP56_TRIG_PIN >= WIDTH) begin : g_pin_check
    $error("gp56_top: shared input pin outside the port");
  end

  // register state; each register has its own next value and flop set
  logic [WIDTH-1:0] p5_data_q;
  logic [WIDTH-1:0] p5_data_d;
  logic [WIDTH-1:0] p5_dir_q;
  logic [WIDTH-1:0] p5_dir_d;
  logic [WIDTH-1:0] p5_pu_q;
  logic [WIDTH-1:0] p5_pu_d;
  logic [WIDTH-1:0] p6_data_q;
  logic [WIDTH-1:0] p6_data_d;
  logic [WIDTH-1:0] p6_dir_q;
  logic [WIDTH-1:0] p6_dir_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // exact match of the bus address against one register offset;
  // partial decoding would alias other ports onto these registers
  function automatic logic addr_hit(
    input logic [15:0] addr,
    input logic [15:0] offset
  );
    addr_hit = (addr == offset);
  endfunction : addr_hit

  // mixes stored data and live pin level per direction bit;
  // an output bit reads back what software wrote, not the pin,
  // so a loaded output cannot corrupt a read-modify-write
  function automatic logic [WIDTH-1:0] port_read(
    input logic [WIDTH-1:0] dir,
    input logic [WIDTH-1:0] data,
    input logic [WIDTH-1:0] pin
  );
    port_read = (dir & data) | (~dir & pin);
  endfunction : port_read

  // gates one read source onto the shared read bus
  function automatic logic [7:0] read_gate(
    input logic hit,
    input logic [7:0] value
  );
    read_gate = {8{hit}} & value;
  endfunction : read_gate

  // keeps the old value unless this write hits the register
  function automatic logic [WIDTH-1:0] reg_next(
    input logic we,
    input logic [WIDTH-1:0] old_val,
    input logic [WIDTH-1:0] new_val
  );
    reg_next = we ? new_val : old_val;
  endfunction : reg_next

  // address decode, one wire per register
  wire logic hit_p5_data = addr_hit(reg_addr, gp56_pkg::GP56_ADDR_P5_DATA);
  wire logic hit_p5_dir = addr_hit(reg_addr, gp56_pkg::GP56_ADDR_P5_DIR);
  wire logic hit_p5_pu = addr_hit(reg_addr, gp56_pkg::GP56_ADDR_P5_PULLUP);
  wire logic hit_p6_data = addr_hit(reg_addr, gp56_pkg::GP56_ADDR_P6_DATA);
  wire logic hit_p6_dir = addr_hit(reg_addr, gp56_pkg::GP56_ADDR_P6_DIR);
  wire logic hit_any = hit_p5_data | hit_p5_dir | hit_p5_pu |
                       hit_p6_data | hit_p6_dir;

  // shared inputs see the pin whatever its direction
  assign ext_irq_in = p5_pin_i; // [R2]
  assign timer_event_in = p5_pin_i[gp56_pkg::GP56_TIMER_PIN]; // [R2]
  assign converter_trigger_in = p5_pin_i[gp56_pkg::GP56_TRIG_PIN]; // [R2]

  // write enables; a write to an unmapped offset changes nothing
  wire logic we_p5_data = reg_wr & hit_p5_data;
  wire logic we_p5_dir = reg_wr & hit_p5_dir;
  wire logic we_p5_pu = reg_wr & hit_p5_pu;
  wire logic we_p6_data = reg_wr & hit_p6_data;
  wire logic we_p6_dir = reg_wr & hit_p6_dir;

  // next register values; data registers take writes in any
  // direction, so software can preset a pin before enabling it
  assign p5_data_d = reg_next(we_p5_data, p5_data_q, reg_wdata);
  assign p5_dir_d = reg_next(we_p5_dir, p5_dir_q, reg_wdata); // [R1]
  assign p5_pu_d = reg_next(we_p5_pu, p5_pu_q, reg_wdata); // [R5]
  assign p6_data_d = reg_next(we_p6_data, p6_data_q, reg_wdata); // [R7]
  assign p6_dir_d = reg_next(we_p6_dir, p6_dir_q, reg_wdata); // [R7]

  // port five data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) p5_data_q <= gp56_pkg::GP56_RST_VAL;
    else p5_data_q <= p5_data_d;
  end

  // port five direction; reset leaves every pin an input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) p5_dir_q <= gp56_pkg::GP56_RST_VAL;
    else p5_dir_q <= p5_dir_d;
  end

  // port five pull-up control; off after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) p5_pu_q <= gp56_pkg::GP56_RST_VAL; // [R6]
    else p5_pu_q <= p5_pu_d;
  end

  // port six data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) p6_data_q <= gp56_pkg::GP56_RST_VAL; // [R7]
    else p6_data_q <= p6_data_d;
  end

  // port six direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) p6_dir_q <= gp56_pkg::GP56_RST_VAL; // [R7]
    else p6_dir_q <= p6_dir_d;
  end

  // both ports as software sees them; input bits follow the pin,
  // which is taken as already synchronous to clk
  wire logic [WIDTH-1:0] p5_view = port_read(p5_dir_q, p5_data_q, p5_pin_i);
  wire logic [WIDTH-1:0] p6_view = port_read(p6_dir_q, p6_data_q, p6_pin_i);

  // read sources; offsets are distinct, so one source at most is on
  wire logic [7:0] rd_p5_data = read_gate(hit_p5_data, p5_view); // [R8]
  wire logic [7:0] rd_p5_dir =
    read_gate(hit_p5_dir, gp56_pkg::GP56_WO_READ); // [R9]
  wire logic [7:0] rd_p5_pu = read_gate(hit_p5_pu, p5_pu_q);
  wire logic [7:0] rd_p6_data = read_gate(hit_p6_data, p6_view); // [R10]
  wire logic [7:0] rd_p6_dir =
    read_gate(hit_p6_dir, gp56_pkg::GP56_WO_READ); // [R11]
  wire logic [7:0] rd_unmapped =
    read_gate(~hit_any, gp56_pkg::GP56_UNMAPPED_READ);

  // read mux as a plain or of the gated sources
  assign rdata_d = rd_p5_data | rd_p5_dir | rd_p5_pu | rd_p6_data |
                   rd_p6_dir | rd_unmapped;

  // read data valid only in the cycle after the strobe; clearing
  // it otherwise keeps stale data off the shared bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= '0;
    else if (reg_rd) rdata_q <= rdata_d;
    else rdata_q <= '0;
  end
  assign reg_rdata = rdata_q;

  // pin drivers: both ports follow the same power mode rules;
  // drive, enable and pull-up change one cycle after the register
  // or the mode, so a write never glitches the pin mid-cycle.
  // sleep modes freeze the last drive; standby and watch release
  // the pins, except that an enabled pull-up shows a high level.
  // unknown mode codes fall back to normal operation, the safe
  // choice if system control briefly shows two modes at once.

  gp56_pin_ctl #(.WIDTH(WIDTH)) u_p5 (
    .clk(clk),
    .rst_n(rst_n),
    .power_mode(power_mode),
    .dir(p5_dir_q),
    .data(p5_data_q),
    .pullup_req(p5_pu_q),
    .pin_o(p5_pin_o),
    .pin_oe(p5_pin_oe),
    .pullup_on(p5_pullup_on)
  );

  // port six has no pull-up control
  gp56_pin_ctl #(.WIDTH(WIDTH)) u_p6 (
    .clk(clk),
    .rst_n(rst_n),
    .power_mode(power_mode),
    .dir(p6_dir_q),
    .data(p6_data_q),
    .pullup_req({WIDTH{1'b0}}),
    .pin_o(p6_pin_o),
    .pin_oe(p6_pin_oe),
    .pullup_on()
  );
endmodule : gp56_top
`default_nettype wire

// file: dv/gp56_props.sv
// Purpose: port checks
// Assumes: top ports
// Notes: bind at foot
`timescale 1ns/100ps
`default_nettype none
module gp56_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] power_mode,
  input wire logic [7:0] p5_pin_i,
  input wire logic [7:0] p5_pin_o,
  input wire logic [7:0] p5_pin_oe,
  input wire logic [7:0] p5_pullup_on,
  input wire logic [7:0] ext_irq_in,
  input wire logic timer_event_in,
  input wire logic converter_trigger_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // taps follow the pin in any direction
  irq_tap_a: assert property (ext_irq_in == p5_pin_i)
    else $error("irq tap");
  evt_tap_a: assert property ({timer_event_in, converter_trigger_in}
    == p5_pin_i[6:5]) else $error("event tap");
  dir5_read_a: assert property (reg_rd && reg_addr == 16'hffe8
    |=> reg_rdata == 8'hff) else $error("dir5 read");
  dir6_read_a: assert property (reg_rd && reg_addr == 16'hffe9
    |=> reg_rdata == 8'hff) else $error("dir6 read");
  pullup_input_a: assert property (power_mode == 6'h01 ##1
    power_mode == 6'h01 |-> (p5_pullup_on & p5_pin_oe) == 8'h00)
    else $error("pullup on output");
  pullup_reset_a: assert property ($rose(rst_n) |->
    p5_pullup_on == 8'h00) else $error("pullup after reset");
  sleep_hold_a: assert property (power_mode == 6'h04 ##1
    power_mode == 6'h04 |-> $stable(p5_pin_oe)) else $error("hold");
  standby_high_a: assert property (power_mode[5:4] != 2'h0 ##1
    power_mode[5:4] != 2'h0 |-> p5_pin_oe == p5_pullup_on &&
    p5_pin_o == p5_pin_oe) else $error("standby level");
endmodule : gp56_props
bind gp56_top gp56_props u_props (.*);
`default_nettype wire

// file: dv/gp56_board.sv
// Purpose: board on the pins
// Assumes: fixed weak board levels
// Notes: pull-up wins over board
`timescale 1ns/100ps
`default_nettype none
module gp56_board (
  input wire logic [7:0] p5_o,
  input wire logic [7:0] p5_oe,
  input wire logic [7:0] p5_pu,
  input wire logic [7:0] p6_o,
  input wire logic [7:0] p6_oe,
  output logic [7:0] p5_lvl,
  output logic [7:0] p6_lvl
);
  // driven pins show the drive, else pull-up or board level
  assign p5_lvl = (p5_oe & p5_o) | (~p5_oe & (p5_pu | 8'h3c));
  assign p6_lvl = (p6_oe & p6_o) | (~p6_oe & 8'h5a);
endmodule : gp56_board
`default_nettype wire

// file: dv/gp56_top_bench.sv
// Purpose: register and pin tests
// Assumes: board levels 3c and 5a
// Notes: pins settle a cycle late
`timescale 1ns/100ps
`default_nettype none
module gp56_top_bench;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, p5_pin_i, p5_pin_o, p5_pin_oe;
  logic [7:0] p5_pullup_on, p6_pin_i, p6_pin_o, p6_pin_oe, ext_irq_in;
  logic [5:0] power_mode = 6'h01;
  logic timer_event_in, converter_trigger_in;
  int mismatches = 0, checks = 0, cyc = 0;
  gp56_top DUT (.*);
  gp56_board u_board (.p5_o(p5_pin_o), .p5_oe(p5_pin_oe),
    .p5_pu(p5_pullup_on), .p6_o(p6_pin_o), .p6_oe(p6_pin_oe),
    .p5_lvl(p5_pin_i), .p6_lvl(p6_pin_i));
  initial forever #5 clk = ~clk;
  // hang guard, far above the run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(logic [7:0] g, logic [7:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: %h not %h", $time, g, e);
    end
  endtask : chk
  task automatic nap;
    @(posedge clk);
    #1;
  endtask : nap
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic md(logic [5:0] m);
    @(posedge clk);
    power_mode <= m;
    nap();
  endtask : md
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    nap();
    chk(p5_pin_oe | p6_pin_oe, 8'h00);
    chk(p5_pullup_on, 8'h00);
    rd(16'hffd9, 8'h5a);
    $display("reset test done");
    wr(16'hffd8, 8'ha5);
    wr(16'hffe8, 8'h0f);
    nap();
    chk(p5_pin_oe, 8'h0f);
    chk(ext_irq_in, 8'h35);
    chk({6'h00, timer_event_in, converter_trigger_in}, 8'h01);
    rd(16'hffd8, (8'h0f & 8'ha5) | (8'hf0 & 8'h3c));
    rd(16'hffe8, 8'hff);
    rd(16'hffe0, 8'h00);
    wr(16'hffd9, 8'h96);
    wr(16'hffe9, 8'hf0);
    nap();
    chk(p6_pin_oe, 8'hf0);
    chk(p6_pin_o & p6_pin_oe, 8'h90);
    rd(16'hffd9, (8'hf0 & 8'h96) | (8'h0f & 8'h5a));
    rd(16'hffe9, 8'hff);
    $display("port test done");
    wr(16'hffef, 8'hff);
    nap();
    chk(p5_pullup_on, 8'hf0);
    rd(16'hffef, 8'hff);
    md(6'h04);
    wr(16'hffe8, 8'h00);
    nap();
    chk(p5_pin_oe, 8'h0f);
    md(6'h08);
    chk(p5_pin_oe, 8'h0f);
    wr(16'hffef, 8'h3c);
    md(6'h10);
    chk(p5_pin_oe, 8'h3c);
    chk(p5_pin_o, 8'h3c);
    chk(p6_pin_oe, 8'h00);
    md(6'h20);
    chk(p5_pin_oe, 8'h3c);
    chk(p5_pin_o, 8'h3c);
    md(6'h02);
    chk(p5_pin_oe, 8'h00);
    $display("mode test done");
    finish_test();
  end
endmodule : gp56_top_bench
`default_nettype wire
